// ===== lpm_pkg.sv
// Package: constants, types and contract of the low-power mode controller
// Contract
// - Supply-drop reset holds reset except in Shutdown
// - Reset threshold starts lowest, option pins raise
// - Enabled detector flags falling and/or rising crossings
// - Analog supply monitor reports functional range
// - Run after reset; low-power only by software
// - Sleep halts processor; interrupt, pin, calendar, LSE or radio event wakes it
// - Low-power run: low regulator, 2 MHz, radio off
// - Low-power sleep only from low-power run
// - Stop modes retain everything, low-speed oscillator on
// - Stop 0 main regulator; Stop 2 low leakage
// - Standby powers core off, supply-drop reset on
// - Standby loses RAM except optional retainable bank
// - Standby I/O pull state chosen by software
// - Standby wakes on reset, watchdog, pin, calendar, radio
// - Standby wakeup clock is internal 16 MHz
// - Shutdown: no supply monitoring, no backup switch
// - Shutdown loses all RAM and registers except event flags
// - Shutdown wakes on reset, pin, calendar; never watchdog
// - Shutdown wakeup clock is multispeed 4 MHz
// - Applied state is shallower of processor and radio
// - Wakeup peripherals may start 16 MHz in Stop
package lpm_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam logic [7:0] EVT_OFS = 8'h08;
    localparam logic [7:0] IOCFG_OFS = 8'h0C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] IOCFG_RST = 32'h0000_0000;
    localparam logic [2:0] BOR_LVL_RST = 3'h0;
    localparam logic [3:0] M_RUN = 4'h0;
    localparam logic [3:0] M_SLEEP = 4'h1;
    localparam logic [3:0] M_LPRUN = 4'h2;
    localparam logic [3:0] M_LPSLEEP = 4'h3;
    localparam logic [3:0] M_STOP0 = 4'h4;
    localparam logic [3:0] M_STOP1 = 4'h5;
    localparam logic [3:0] M_STOP2 = 4'h6;
    localparam logic [3:0] M_STBY = 4'h7;
    localparam logic [3:0] M_SHUT = 4'h8;
    localparam logic [5:0] LPRUN_MAX_MHZ = 6'h02;
    localparam logic [5:0] MSI_WAKE_MHZ = 6'h04;
    localparam logic [5:0] MSI_MAX_MHZ = 6'h30;
    localparam logic [1:0] OPT_CAPTURE = 2'h2;
    localparam int EV_TVD_FALL = 0;
    localparam int EV_TVD_RISE = 1;
    localparam int EV_WKPIN = 2;
    localparam int EV_RTC = 3;
    localparam int EV_LSE = 4;
    localparam int EV_RADIO = 5;
    localparam int EV_WDG = 6;
    localparam int EV_XRST = 7;
    typedef enum logic [8:0] {
        ST_RUN = 9'h001, ST_SLEEP = 9'h002, ST_LPRUN = 9'h004,
        ST_LPSLEEP = 9'h008, ST_STOP0 = 9'h010, ST_STOP1 = 9'h020,
        ST_STOP2 = 9'h040, ST_STBY = 9'h080, ST_SHUT = 9'h100
    } pm_state_e;
    typedef struct packed {
        logic supply_low;
        logic tvd_low;
        logic analog_ok;
        logic external_reset_pin_n;
        logic watchdog_reset;
        logic wakeup_pin;
        logic rtc_event;
        logic lse_fail;
        logic radio_wake;
        logic irq_pending;
        logic hsi_request;
        logic [1:0] radio_req;
        logic [2:0] opt_level;
    } pin_s;
    typedef struct packed {
        logic [14:0] rsvd;
        logic [5:0] msi_mhz;
        logic stop_hsi;
        logic retain;
        logic wk_pol;
        logic tvd_rise;
        logic tvd_fall;
        logic tvd_en;
        logic go;
        logic [3:0] mode;
    } ctrl_s;
    typedef struct packed {
        logic dev_rst_n;
        logic sdr_en;
        logic [2:0] bor_lvl;
        logic tvd_irq;
        logic analog_ok;
        logic cpu_halt;
        logic periph_clk_on;
        logic main_reg_on;
        logic lp_reg_on;
        logic core_on;
        logic low_leak;
        logic main_ram_on;
        logic sec_ram_on;
        logic ret_ram_on;
        logic ls_osc_on;
        logic hsi_on;
        logic clk_src_hsi;
        logic [5:0] msi_mhz;
        logic radio_en;
        logic backup_sw_en;
        logic io_hold;
        logic resume;
    } pwr_s;
    typedef struct packed {
        pin_s s1;
        pin_s s2;
        pin_s s3;
        logic wr_pend;
        logic [7:0] addr;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        ctrl_s ctrl;
        logic [31:0] iocfg;
        logic [7:0] evt;
        logic [3:0] cpu_tgt;
        pm_state_e st;
        logic [1:0] opt_cnt;
        pwr_s out;
    } st_s;
endpackage

// ===== low_power_mode_controller.sv
// Low-power mode controller with supply supervision and AHB-Lite registers
`timescale 1ns/1ps
module low_power_mode_controller (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire lpm_pkg::pin_s pins,
    output lpm_pkg::pwr_s pwr,
    output logic [31:0] io_standby_cfg
);
    lpm_pkg::st_s q;
    lpm_pkg::st_s n;
    logic [1:0] unused_size;

    function automatic lpm_pkg::pm_state_e code_to_state(input logic [3:0] c);
        lpm_pkg::pm_state_e s;
        s = lpm_pkg::ST_RUN;
        case (c)
            lpm_pkg::M_SLEEP: s = lpm_pkg::ST_SLEEP;
            lpm_pkg::M_LPRUN: s = lpm_pkg::ST_LPRUN;
            lpm_pkg::M_LPSLEEP: s = lpm_pkg::ST_LPSLEEP;
            lpm_pkg::M_STOP0: s = lpm_pkg::ST_STOP0;
            lpm_pkg::M_STOP1: s = lpm_pkg::ST_STOP1;
            lpm_pkg::M_STOP2: s = lpm_pkg::ST_STOP2;
            lpm_pkg::M_STBY: s = lpm_pkg::ST_STBY;
            lpm_pkg::M_SHUT: s = lpm_pkg::ST_SHUT;
            default: s = lpm_pkg::ST_RUN;
        endcase
        return s;
    endfunction

    function automatic logic is_stop(input lpm_pkg::pm_state_e s);
        return (s == lpm_pkg::ST_STOP0) || (s == lpm_pkg::ST_STOP1) || (s == lpm_pkg::ST_STOP2);
    endfunction

    function automatic logic is_stop_code(input logic [3:0] c);
        return (c == lpm_pkg::M_STOP0) || (c == lpm_pkg::M_STOP1) || (c == lpm_pkg::M_STOP2);
    endfunction

    // Edge detectors on synchronised pins
    logic tvd_fall_ev;
    logic tvd_rise_ev;
    logic wk_edge;
    logic rtc_edge;
    logic lse_edge;
    logic radio_edge;
    logic wdg_edge;
    logic xrst_edge;
    logic [7:0] ev_set;
    logic [3:0] radio_code;
    logic [3:0] eff_code;
    logic go_ok;
    logic wake_light;
    logic wake_stby;
    logic wake_shut;

    assign unused_size = hsize[1:0];

    always_comb begin
        tvd_fall_ev = q.ctrl.tvd_en && q.ctrl.tvd_fall && q.s2.tvd_low && !q.s3.tvd_low;
        tvd_rise_ev = q.ctrl.tvd_en && q.ctrl.tvd_rise && !q.s2.tvd_low && q.s3.tvd_low;
        if (q.ctrl.wk_pol) begin
            wk_edge = q.s2.wakeup_pin && !q.s3.wakeup_pin;
        end else begin
            wk_edge = !q.s2.wakeup_pin && q.s3.wakeup_pin;
        end
        rtc_edge = q.s2.rtc_event && !q.s3.rtc_event;
        lse_edge = q.s2.lse_fail && !q.s3.lse_fail;
        radio_edge = q.s2.radio_wake && !q.s3.radio_wake;
        wdg_edge = q.s2.watchdog_reset && !q.s3.watchdog_reset;
        xrst_edge = !q.s2.external_reset_pin_n && q.s3.external_reset_pin_n;
        ev_set = '0;
        ev_set[lpm_pkg::EV_TVD_FALL] = tvd_fall_ev;
        ev_set[lpm_pkg::EV_TVD_RISE] = tvd_rise_ev;
        ev_set[lpm_pkg::EV_WKPIN] = wk_edge;
        ev_set[lpm_pkg::EV_RTC] = rtc_edge;
        ev_set[lpm_pkg::EV_LSE] = lse_edge;
        ev_set[lpm_pkg::EV_RADIO] = radio_edge;
        ev_set[lpm_pkg::EV_WDG] = wdg_edge;
        ev_set[lpm_pkg::EV_XRST] = xrst_edge;
        // Radio request mapped to a depth code
        case (q.s2.radio_req)
            2'h0: radio_code = lpm_pkg::M_RUN;
            2'h1: radio_code = lpm_pkg::M_STOP2;
            2'h2: radio_code = lpm_pkg::M_STBY;
            default: radio_code = lpm_pkg::M_SHUT;
        endcase
        wake_light = q.s2.irq_pending || wk_edge || rtc_edge || lse_edge || radio_edge;
        wake_stby = xrst_edge || wdg_edge || wk_edge || rtc_edge || lse_edge || radio_edge;
        wake_shut = xrst_edge || wk_edge || rtc_edge;
        go_ok = q.wr_pend && (q.addr == lpm_pkg::CTRL_OFS) && hwdata[4]
            && ((q.cpu_tgt == lpm_pkg::M_RUN) || (q.cpu_tgt == lpm_pkg::M_LPRUN))
            && (hwdata[3:0] <= lpm_pkg::M_SHUT)
            && ((hwdata[3:0] != lpm_pkg::M_LPSLEEP) || (q.cpu_tgt == lpm_pkg::M_LPRUN));
        eff_code = lpm_pkg::M_RUN;

        n = q;
        n.s1 = pins;
        n.s2 = q.s1;
        n.s3 = q.s2;
        n.out.resume = 1'b0;
        n.out.tvd_irq = tvd_fall_ev || tvd_rise_ev;
        n.hready = 1'b1;
        n.hresp = 1'b0;

        // Address phase and read data
        n.wr_pend = 1'b0;
        n.hrdata = '0;
        if (hsel && htrans[1] && hready) begin
            n.wr_pend = hwrite;
            n.addr = haddr[7:0];
            if (!hwrite) begin
                if (haddr[7:0] == lpm_pkg::CTRL_OFS) begin
                    n.hrdata = q.ctrl;
                end else if (haddr[7:0] == lpm_pkg::STAT_OFS) begin
                    n.hrdata = {5'h00, q.s2.radio_req, q.out.msi_mhz, q.out.clk_src_hsi, q.out.bor_lvl,
                        q.out.dev_rst_n, q.out.analog_ok, q.cpu_tgt, q.st};
                end else if (haddr[7:0] == lpm_pkg::EVT_OFS) begin
                    n.hrdata = {24'h00_0000, q.evt};
                end else if (haddr[7:0] == lpm_pkg::IOCFG_OFS) begin
                    n.hrdata = q.iocfg;
                end else begin
                    n.hrdata = '0;
                end
            end
        end

        // Data phase writes; event flags set wins over clear
        n.evt = q.evt | ev_set;
        if (q.wr_pend) begin
            if (q.addr == lpm_pkg::CTRL_OFS) begin
                n.ctrl = hwdata;
                n.ctrl.go = 1'b0;
                n.ctrl.rsvd = '0;
            end else if (q.addr == lpm_pkg::EVT_OFS) begin
                n.evt = (q.evt & ~hwdata[7:0]) | ev_set;
            end else if (q.addr == lpm_pkg::IOCFG_OFS) begin
                n.iocfg = hwdata;
            end
        end
        if (go_ok) begin
            n.cpu_tgt = hwdata[3:0];
        end

        // Wakeup handling per processor mode
        if ((q.cpu_tgt == lpm_pkg::M_SLEEP || is_stop_code(q.cpu_tgt)) && wake_light) begin
            n.cpu_tgt = lpm_pkg::M_RUN;
            n.out.resume = 1'b1;
            if (is_stop_code(q.cpu_tgt)) begin
                n.out.clk_src_hsi = q.ctrl.stop_hsi;
                n.out.msi_mhz = (q.ctrl.msi_mhz > lpm_pkg::MSI_MAX_MHZ) ? lpm_pkg::MSI_MAX_MHZ : q.ctrl.msi_mhz;
            end
        end else if (q.cpu_tgt == lpm_pkg::M_LPSLEEP && wake_light) begin
            n.cpu_tgt = lpm_pkg::M_LPRUN;
            n.out.resume = 1'b1;
        end else if (q.cpu_tgt == lpm_pkg::M_STBY && wake_stby) begin
            n.cpu_tgt = lpm_pkg::M_RUN;
            n.out.clk_src_hsi = 1'b1;
            n.ctrl = lpm_pkg::CTRL_RST;
        end else if (q.cpu_tgt == lpm_pkg::M_SHUT && wake_shut) begin
            n.cpu_tgt = lpm_pkg::M_RUN;
            n.out.clk_src_hsi = 1'b0;
            n.out.msi_mhz = lpm_pkg::MSI_WAKE_MHZ;
            n.ctrl = lpm_pkg::CTRL_RST;
            n.iocfg = lpm_pkg::IOCFG_RST;
        end

        // Applied state is the shallower request
        eff_code = (n.cpu_tgt < radio_code) ? n.cpu_tgt : radio_code;
        n.st = code_to_state(eff_code);

        // Low-power run clock ceiling
        if (n.st == lpm_pkg::ST_LPRUN || n.st == lpm_pkg::ST_LPSLEEP) begin
            if (n.out.msi_mhz > lpm_pkg::LPRUN_MAX_MHZ) begin
                n.out.msi_mhz = lpm_pkg::LPRUN_MAX_MHZ;
            end
            // Multispeed source even after a 16 MHz stop exit
            n.out.clk_src_hsi = 1'b0;
        end

        // Option threshold caught once after reset
        if (q.opt_cnt != 2'h3) begin
            n.opt_cnt = q.opt_cnt + 2'h1;
        end
        if (q.opt_cnt == lpm_pkg::OPT_CAPTURE) begin
            n.out.bor_lvl = q.s2.opt_level;
        end

        // Power, clock and retention controls
        n.out.sdr_en = (n.st != lpm_pkg::ST_SHUT);
        n.out.backup_sw_en = (n.st != lpm_pkg::ST_SHUT);
        n.out.dev_rst_n = !(n.out.sdr_en && q.s2.supply_low);
        n.out.analog_ok = q.s2.analog_ok;
        n.out.cpu_halt = (n.st != lpm_pkg::ST_RUN) && (n.st != lpm_pkg::ST_LPRUN);
        n.out.periph_clk_on = (n.st == lpm_pkg::ST_RUN) || (n.st == lpm_pkg::ST_SLEEP)
            || (n.st == lpm_pkg::ST_LPRUN) || (n.st == lpm_pkg::ST_LPSLEEP);
        n.out.main_reg_on = (n.st == lpm_pkg::ST_RUN) || (n.st == lpm_pkg::ST_SLEEP)
            || (n.st == lpm_pkg::ST_STOP0);
        n.out.lp_reg_on = (n.st == lpm_pkg::ST_LPRUN) || (n.st == lpm_pkg::ST_LPSLEEP)
            || (n.st == lpm_pkg::ST_STOP1) || (n.st == lpm_pkg::ST_STOP2)
            || ((n.st == lpm_pkg::ST_STBY) && q.ctrl.retain);
        n.out.core_on = (n.st != lpm_pkg::ST_STBY) && (n.st != lpm_pkg::ST_SHUT);
        n.out.low_leak = (n.st == lpm_pkg::ST_STOP2);
        n.out.main_ram_on = n.out.core_on;
        n.out.sec_ram_on = n.out.core_on;
        n.out.ret_ram_on = n.out.core_on || ((n.st == lpm_pkg::ST_STBY) && q.ctrl.retain);
        n.out.ls_osc_on = (n.st != lpm_pkg::ST_SHUT);
        n.out.hsi_on = is_stop(n.st) ? q.s2.hsi_request : n.out.core_on;
        n.out.radio_en = (n.st != lpm_pkg::ST_LPRUN) && (n.st != lpm_pkg::ST_LPSLEEP)
            && (n.st != lpm_pkg::ST_SHUT);
        n.out.io_hold = (n.st == lpm_pkg::ST_STBY);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.hready <= 1'b1;
            q.ctrl <= lpm_pkg::CTRL_RST;
            q.iocfg <= lpm_pkg::IOCFG_RST;
            q.cpu_tgt <= lpm_pkg::M_RUN;
            q.st <= lpm_pkg::ST_RUN;
            q.out.bor_lvl <= lpm_pkg::BOR_LVL_RST;
            q.out.sdr_en <= 1'b1;
            q.out.periph_clk_on <= 1'b1;
            q.out.main_reg_on <= 1'b1;
            q.out.core_on <= 1'b1;
            q.out.main_ram_on <= 1'b1;
            q.out.sec_ram_on <= 1'b1;
            q.out.ret_ram_on <= 1'b1;
            q.out.ls_osc_on <= 1'b1;
            q.out.hsi_on <= 1'b1;
            q.out.msi_mhz <= lpm_pkg::MSI_WAKE_MHZ;
            q.out.radio_en <= 1'b1;
            q.out.backup_sw_en <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign hreadyout = q.hready;
    assign hresp = q.hresp;
    assign hrdata = q.hrdata;
    assign pwr = q.out;
    assign io_standby_cfg = q.iocfg;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_sdr_holds_reset: assert property (
        (q.s2.supply_low && n.st != lpm_pkg::ST_SHUT) |=> !q.out.dev_rst_n)
        else $error("supply drop did not hold reset");
    a_bor_default: assert property (
        (q.opt_cnt != 2'h3) |-> (q.out.bor_lvl == lpm_pkg::BOR_LVL_RST))
        else $error("threshold not lowest before capture");
    a_tvd_fall_irq: assert property (
        tvd_fall_ev |=> (q.out.tvd_irq && q.evt[lpm_pkg::EV_TVD_FALL]))
        else $error("falling crossing not flagged");
    a_analog_report: assert property (
        1'b1 |=> (q.out.analog_ok == $past(q.s2.analog_ok)))
        else $error("analog monitor not reported");
    a_run_needs_go: assert property (
        (q.cpu_tgt == lpm_pkg::M_RUN && !go_ok) |=> (q.cpu_tgt == lpm_pkg::M_RUN))
        else $error("low-power entry without software");
    a_sleep_wake: assert property (
        (q.cpu_tgt == lpm_pkg::M_SLEEP && q.s2.irq_pending) |=> (q.cpu_tgt == lpm_pkg::M_RUN && q.out.resume))
        else $error("sleep not woken by interrupt");
    a_lprun_clock: assert property (
        (q.st == lpm_pkg::ST_LPRUN) |-> (q.out.msi_mhz <= lpm_pkg::LPRUN_MAX_MHZ && !q.out.clk_src_hsi))
        else $error("low-power run clock too fast");
    a_lpsleep_entry: assert property (
        $rose(q.cpu_tgt == lpm_pkg::M_LPSLEEP) |-> ($past(q.cpu_tgt) == lpm_pkg::M_LPRUN))
        else $error("low-power sleep not from low-power run");
    a_stop_retain: assert property (
        is_stop(q.st) |-> (q.out.ls_osc_on && q.out.main_ram_on && q.out.ret_ram_on && q.out.core_on))
        else $error("stop mode lost retention");
    a_stop_regs: assert property (
        (q.st == lpm_pkg::ST_STOP0) |-> (q.out.main_reg_on && !q.out.low_leak))
        else $error("stop 0 regulator wrong");
    a_standby_power: assert property (
        (q.st == lpm_pkg::ST_STBY) |-> (!q.out.core_on && q.out.sdr_en && !q.out.main_ram_on && q.out.io_hold))
        else $error("standby power wrong");
    a_standby_clock: assert property (
        (q.cpu_tgt == lpm_pkg::M_STBY && wake_stby) |=> (q.out.clk_src_hsi && q.cpu_tgt == lpm_pkg::M_RUN))
        else $error("standby wake clock wrong");
    a_shut_no_monitor: assert property (
        (q.st == lpm_pkg::ST_SHUT) |-> (!q.out.sdr_en && !q.out.backup_sw_en && q.out.dev_rst_n))
        else $error("monitoring active in shutdown");
    a_shut_no_wdg: assert property (
        (q.cpu_tgt == lpm_pkg::M_SHUT && !wake_shut) |=> (q.cpu_tgt == lpm_pkg::M_SHUT))
        else $error("shutdown left without valid source");
    a_shut_clock: assert property (
        (q.cpu_tgt == lpm_pkg::M_SHUT && wake_shut) |=> (!q.out.clk_src_hsi && q.out.msi_mhz == lpm_pkg::MSI_WAKE_MHZ))
        else $error("shutdown wake clock wrong");
    a_radio_run: assert property (
        (q.s2.radio_req == 2'h0) |=> (q.st == lpm_pkg::ST_RUN))
        else $error("radio run request not applied");
    a_stop_hsi: assert property (
        (is_stop(n.st) && q.s2.hsi_request) |=> q.out.hsi_on)
        else $error("wakeup peripheral denied 16 MHz");
endmodule

// ===== lpm_far_side.sv
// Far-side model: processor wake sources and radio power requests
`timescale 1ns/1ps
module lpm_far_side (
    input wire logic hclk,
    output lpm_pkg::pin_s pins
);
    lpm_pkg::pin_s p;
    assign pins = p;
    initial begin
        p = '0;
        p.analog_ok = 1'b1;
        p.external_reset_pin_n = 1'b1;
        p.radio_req = 2'h3; // Radio idle
    end
    task automatic set(input int k, input logic v);
        case (k)
            lpm_pkg::EV_WKPIN: p.wakeup_pin <= v;
            lpm_pkg::EV_RTC: p.rtc_event <= v;
            lpm_pkg::EV_LSE: p.lse_fail <= v;
            lpm_pkg::EV_RADIO: p.radio_wake <= v;
            lpm_pkg::EV_WDG: p.watchdog_reset <= v;
            lpm_pkg::EV_XRST: p.external_reset_pin_n <= !v;
            default: p.irq_pending <= v;
        endcase
    endtask
    task automatic pulse(input int k);
        @(posedge hclk);
        set(k, 1'b1);
        repeat (4) @(posedge hclk);
        set(k, 1'b0);
    endtask
    task automatic set_radio(input logic [1:0] v);
        @(posedge hclk);
        p.radio_req <= v; // Radio state machine request
    endtask
endmodule

// ===== tb.sv
// Testbench of the low-power mode controller
`timescale 1ns/1ps
`define CHK(g, x, m) begin checks_done++; if ((g) !== (x)) begin error_cnt++; $display("CHECK FAILED at %0t: %s", $time, m); end end
module tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
    logic [1:0] htrans;
    logic [2:0] hsize, opt;
    logic [31:0] haddr, hwdata, hrdata, io_standby_cfg, rnd;
    lpm_pkg::pin_s pins;
    lpm_pkg::pwr_s pwr;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int error_cnt = 0;
    int checks_done = 0;
    int seed = 42;
    int r;
    int irq_cnt = 0;
    int rsm_cnt = 0;
    logic [31:0] exp_w, msk_w;
    int src[6] = '{lpm_pkg::EV_WKPIN, lpm_pkg::EV_RTC, lpm_pkg::EV_LSE, lpm_pkg::EV_RADIO, lpm_pkg::EV_WDG,
        lpm_pkg::EV_XRST};
    int sx[3] = '{0, 1, 5};
    assign hready = hreadyout;
    low_power_mode_controller DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .pins(pins), .pwr(pwr), .io_standby_cfg(io_standby_cfg));
    lpm_far_side far (.hclk(hclk), .pins(pins));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [31:0] x,
        input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) begin
            exp_q.push_back(x);
            msk_q.push_back(m);
        end
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic go(input logic [3:0] md, input logic [31:0] x);
        bus(lpm_pkg::CTRL_OFS, 1'b1, x | 32'h10 | {28'h0, md}, 32'h0, 32'h0);
        @(posedge hclk);
    endtask
    task automatic st(input logic [8:0] s);
        bus(lpm_pkg::STAT_OFS, 1'b0, 32'h0, {23'h0, s}, 32'h1FF);
    endtask
    task automatic wake(input int k);
        far.pulse(k);
        repeat (4) @(posedge hclk);
    endtask
    task automatic test_done;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Read data monitor: oldest note against the data phase
    always @(posedge hclk) begin
        if (rd_ph) begin
            exp_w = exp_q.pop_front();
            msk_w = msk_q.pop_front();
            `CHK(hrdata & msk_w, exp_w & msk_w, "read data")
            `CHK(hresp, 1'b0, "response")
        end
        if (pwr.tvd_irq) begin
            irq_cnt++;
        end
        if (pwr.resume) begin
            rsm_cnt++;
        end
        rd_ph <= hsel & htrans[1] & hready & !hwrite;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        test_done();
    end
    initial begin
        {hsel, hwrite, hresetn} = '0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        hsize = 3'h2;
        opt = 3'($random(seed));
        @(posedge hclk);
        far.p.opt_level <= opt;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        bus(lpm_pkg::CTRL_OFS, 1'b0, 32'h0, 32'h0, 32'hFFFF_FFFF);
        st(lpm_pkg::ST_RUN);
        bus(lpm_pkg::STAT_OFS, 1'b0, 32'h0, {14'h0, opt, 15'h0}, 32'h0003_8000);
        `CHK(pwr.dev_rst_n, 1'b1, "out of reset")
        go(lpm_pkg::M_LPSLEEP, 32'h0);
        st(lpm_pkg::ST_RUN);
        go(lpm_pkg::M_SLEEP, 32'h0);
        st(lpm_pkg::ST_SLEEP);
        `CHK({pwr.cpu_halt, pwr.periph_clk_on, pwr.radio_en}, 3'b111, "sleep outputs")
        wake(8);
        st(lpm_pkg::ST_RUN);
        go(lpm_pkg::M_LPRUN, 32'h0);
        st(lpm_pkg::ST_LPRUN);
        `CHK({pwr.lp_reg_on, pwr.main_reg_on}, 2'b10, "lprun regulator")
        `CHK(pwr.msi_mhz, lpm_pkg::LPRUN_MAX_MHZ, "lprun clock")
        go(lpm_pkg::M_LPSLEEP, 32'h0);
        st(lpm_pkg::ST_LPSLEEP);
        wake(8);
        st(lpm_pkg::ST_LPRUN);
        go(lpm_pkg::M_RUN, 32'h0);
        st(lpm_pkg::ST_RUN);
        for (int m = 4; m < 7; m++) begin
            r = $random(seed);
            go(4'(m), {21'h0, r[0], 10'h0});
            st(9'h1 << m);
            `CHK(pwr.ls_osc_on & pwr.main_ram_on & pwr.ret_ram_on, 1'b1, "stop retention")
            `CHK(pwr.main_reg_on, 1'(m == 4), "stop regulator")
            `CHK(pwr.low_leak, 1'(m == 6), "stop leakage")
            `CHK(pwr.hsi_on, 1'b0, "stop hsi idle")
            far.p.hsi_request <= 1'b1;
            repeat (5) @(posedge hclk);
            `CHK(pwr.hsi_on, 1'b1, "stop hsi request")
            far.p.hsi_request <= 1'b0;
            wake(8);
            st(lpm_pkg::ST_RUN);
            `CHK(pwr.clk_src_hsi, r[0], "stop exit clock")
        end
        far.set_radio(2'h0);
        repeat (3) @(posedge hclk);
        go(lpm_pkg::M_STOP1, 32'h400); // Radio in use, 16 MHz exit
        st(lpm_pkg::ST_RUN);
        far.set_radio(2'h3);
        repeat (5) @(posedge hclk);
        st(lpm_pkg::ST_STOP1);
        wake(8);
        st(lpm_pkg::ST_RUN);
        `CHK(pwr.clk_src_hsi, 1'b1, "radio stop exit clock")
        bus(lpm_pkg::CTRL_OFS, 1'b1, 32'hE0, 32'h0, 32'h0);
        far.p.tvd_low <= 1'b1;
        repeat (6) @(posedge hclk);
        far.p.tvd_low <= 1'b0;
        repeat (6) @(posedge hclk);
        bus(lpm_pkg::EVT_OFS, 1'b0, 32'h0, 32'h3, 32'h3);
        bus(lpm_pkg::EVT_OFS, 1'b1, 32'hFF, 32'h0, 32'h0);
        bus(lpm_pkg::EVT_OFS, 1'b0, 32'h0, 32'h0, 32'hFF);
        far.p.analog_ok <= 1'b0;
        repeat (5) @(posedge hclk);
        `CHK(pwr.analog_ok, 1'b0, "analog monitor")
        far.p.analog_ok <= 1'b1;
        foreach (src[i]) begin
            rnd = $random(seed);
            bus(lpm_pkg::IOCFG_OFS, 1'b1, rnd, 32'h0, 32'h0);
            go(lpm_pkg::M_LPRUN, 32'h0);
            `CHK(pwr.clk_src_hsi, 1'b0, "lprun source")
            go(lpm_pkg::M_STBY, 32'h300);
            st(lpm_pkg::ST_STBY);
            `CHK({pwr.core_on, pwr.sdr_en}, 2'b01, "standby supply")
            `CHK({pwr.main_ram_on, pwr.sec_ram_on, pwr.ret_ram_on}, 3'b001, "standby ram")
            `CHK(io_standby_cfg, rnd, "standby io")
            `CHK(pwr.io_hold, 1'b1, "standby io hold")
            wake(src[i]);
            st(lpm_pkg::ST_RUN);
            `CHK(pwr.clk_src_hsi, 1'b1, "standby exit clock")
            bus(lpm_pkg::CTRL_OFS, 1'b0, 32'h0, 32'h0, 32'hFFFF_FFFF);
        end
        foreach (sx[i]) begin
            go(lpm_pkg::M_SHUT, 32'h100);
            st(lpm_pkg::ST_SHUT);
            `CHK({pwr.sdr_en, pwr.backup_sw_en}, 2'b00, "shutdown monitor")
            `CHK({pwr.main_ram_on, pwr.sec_ram_on, pwr.ret_ram_on}, 3'b000, "shutdown ram")
            wake(lpm_pkg::EV_WDG);
            st(lpm_pkg::ST_SHUT);
            wake(src[sx[i]]);
            st(lpm_pkg::ST_RUN);
            `CHK({pwr.clk_src_hsi, pwr.msi_mhz}, {1'b0, lpm_pkg::MSI_WAKE_MHZ}, "shutdown exit clock")
        end
        `CHK(irq_cnt, 2, "detector pulses")
        `CHK(rsm_cnt, 6, "resume pulses")
        far.p.supply_low <= 1'b1;
        repeat (5) @(posedge hclk);
        `CHK(pwr.dev_rst_n, 1'b0, "supply drop")
        far.p.supply_low <= 1'b0;
        repeat (5) @(posedge hclk);
        `CHK(pwr.dev_rst_n, 1'b1, "supply back")
        test_done();
    end
endmodule
